/* rtl/wkt_defs.svh */
// register map, field positions, reset values and limits of the wake-up timer
`ifndef WKT_DEFS_SVH
`define WKT_DEFS_SVH

`define WKT_OFF_LOAD 32'hffff_0340
`define WKT_OFF_VALUE 32'hffff_0344
`define WKT_OFF_CTRL 32'hffff_0348
`define WKT_OFF_CLR 32'hffff_034c
`define WKT_OFF_STAT 32'hffff_0350
`define WKT_OFF_IEN 32'hffff_0354

`define WKT_RST_LOAD 32'h0000_0000
`define WKT_RST_VALUE 32'hffff_ffff
`define WKT_RST_CTRL 11'h000
`define WKT_CTRL_W 11

`define WKT_SRC_HI 10
`define WKT_SRC_LO 9
`define WKT_UP_BIT 8
`define WKT_EN_BIT 7
`define WKT_PER_BIT 6
`define WKT_FMT_HI 5
`define WKT_FMT_LO 4
`define WKT_PRE_HI 3
`define WKT_PRE_LO 0

`define WKT_PRE_D16 4'h4
`define WKT_PRE_D256 4'h8
`define WKT_PRE_D32K 4'hf
`define WKT_MASK_D1 15'h0000
`define WKT_MASK_D16 15'h000f
`define WKT_MASK_D256 15'h00ff
`define WKT_MASK_D32K 15'h7fff

`define WKT_HUN_MAX 8'h63
`define WKT_SEC_MAX 8'h3b
`define WKT_HR24_MAX 8'h17
`define WKT_HR255_MAX 8'hff

`endif

/* rtl/wkt_pkg.sv */
// types of the wake-up timer
package wkt_pkg;

	typedef enum logic [1:0] {
		WKT_SRC_CORE = 2'h0,
		WKT_SRC_LPOSC = 2'h1,
		WKT_SRC_XTAL = 2'h2,
		WKT_SRC_PREC = 2'h3
	} wkt_source_type;

	typedef enum logic [1:0] {
		WKT_FMT_BIN = 2'h0,
		WKT_FMT_RSVD = 2'h1,
		WKT_FMT_HMS24 = 2'h2,
		WKT_FMT_HMS255 = 2'h3
	} wkt_format_type;

endpackage : wkt_pkg

/* rtl/wkt_wakeup_timer.sv */
// 32-bit wake-up timer with apb register slave
// How it works
// - control bits 10:9 pick the prescaler source: core, lp, xtal, precision.
// - control bits 3:0 divide the source by 1, 16, 256 or 32768.
// - control bit 8 high counts up, low (default) counts down.
// - control bit 7 enables counting; cleared the counter holds.
// - control bit 6 high is periodic mode, low is free running.
// - control bits 5:4 pick binary or hh:mm:ss:hundredths up to 23 or 255 h.
// - at the end of the count the counter is reloaded from the load register in periodic mode; free running it wraps to zero or top.
// - the counter runs on from the lp, xtal or precision source while the core clock is stopped.
// - any write to the clear register drops the pending interrupt unless a timeout falls in the same cycle.
// - value register reads the live count, ignores writes, resets all ones.
// - the load register is read/write and resets to zero.
`timescale 1ns/1ns
`include "wkt_defs.svh"

module wkt_wakeup_timer
	import wkt_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// count sources
	input wire logic core_clk_en_i,
	input wire logic lp_osc_i,
	input wire logic xtal_i,
	input wire logic prec_osc_i,
	// interrupt
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [14:0] pre_mask(input logic [3:0] code);
		case (code)
			`WKT_PRE_D16: pre_mask = `WKT_MASK_D16;
			`WKT_PRE_D256: pre_mask = `WKT_MASK_D256;
			`WKT_PRE_D32K: pre_mask = `WKT_MASK_D32K;
			default: pre_mask = `WKT_MASK_D1;
		endcase
	endfunction : pre_mask

	function automatic logic addr_hit(input logic [31:0] a);
		case (a)
			`WKT_OFF_LOAD, `WKT_OFF_VALUE, `WKT_OFF_CTRL,
			`WKT_OFF_CLR, `WKT_OFF_STAT, `WKT_OFF_IEN: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	endfunction : addr_hit

	function automatic logic [31:0] hms_step(
		input logic [31:0] v,
		input logic up
	);
		logic [7:0] c;
		logic [7:0] s;
		logic [7:0] m;
		logic [7:0] h;
		c = v[7:0];
		s = v[15:8];
		m = v[23:16];
		h = v[31:24];
		if (up) begin
			if (c != `WKT_HUN_MAX) begin
				c = c + 8'h01;
			end else begin
				c = 8'h00;
				if (s != `WKT_SEC_MAX) begin
					s = s + 8'h01;
				end else begin
					s = 8'h00;
					if (m != `WKT_SEC_MAX) begin
						m = m + 8'h01;
					end else begin
						m = 8'h00;
						h = h + 8'h01;
					end
				end
			end
		end else begin
			if (c != 8'h00) begin
				c = c - 8'h01;
			end else begin
				c = `WKT_HUN_MAX;
				if (s != 8'h00) begin
					s = s - 8'h01;
				end else begin
					s = `WKT_SEC_MAX;
					if (m != 8'h00) begin
						m = m - 8'h01;
					end else begin
						m = `WKT_SEC_MAX;
						h = h - 8'h01;
					end
				end
			end
		end
		hms_step = {h, m, s, c};
	endfunction : hms_step

	////////////////////////////////////////////////////////////////////////
	// registers and control fields

	logic [31:0] load_r;
	logic [31:0] value_r;
	logic [31:0] value_nxt;
	logic [`WKT_CTRL_W-1:0] ctrl_r;
	logic stat_r;
	logic ien_r;
	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [2:0] osc_prev_r;
	logic [14:0] pre_cnt_r;

	wkt_source_type src;
	wkt_format_type fmt;
	logic count_up;
	logic count_en;
	logic periodic;
	logic [14:0] mask;

	assign src = wkt_source_type'(ctrl_r[`WKT_SRC_HI:`WKT_SRC_LO]);
	assign fmt = wkt_format_type'(ctrl_r[`WKT_FMT_HI:`WKT_FMT_LO]);
	assign count_up = ctrl_r[`WKT_UP_BIT];
	assign count_en = ctrl_r[`WKT_EN_BIT];
	assign periodic = ctrl_r[`WKT_PER_BIT];
	assign mask = pre_mask(ctrl_r[`WKT_PRE_HI:`WKT_PRE_LO]);

	////////////////////////////////////////////////////////////////////////
	// apb access

	logic access;
	logic wr_fire;
	logic hit;

	assign access = psel_i && penable_i;
	assign wr_fire = access && pready_r && pwrite_i;
	assign hit = addr_hit(paddr_i);

	// one wait state: data and error are registered on the same edge that raises pready
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= access && !pready_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (access && !pready_r) begin
			pslverr_r <= !hit;
			prdata_r <= 32'h0000_0000;
			if (!pwrite_i) begin
				case (paddr_i)
					`WKT_OFF_LOAD: prdata_r <= load_r;
					`WKT_OFF_VALUE: prdata_r <= value_r;
					`WKT_OFF_CTRL: prdata_r <= {21'h00_0000, ctrl_r};
					`WKT_OFF_STAT: prdata_r <= {31'h0000_0000, stat_r};
					`WKT_OFF_IEN: prdata_r <= {31'h0000_0000, ien_r};
					default: prdata_r <= 32'h0000_0000;
				endcase
			end
		end else begin
			pslverr_r <= 1'b0;
		end
	end

	assign pready_o = pready_r;
	assign prdata_o = prdata_r;
	assign pslverr_o = pslverr_r;

	// load register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			load_r <= `WKT_RST_LOAD;
		end else if (wr_fire && paddr_i == `WKT_OFF_LOAD) begin
			load_r <= pwdata_i;
		end
	end

	// control register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= `WKT_RST_CTRL;
		end else if (wr_fire && paddr_i == `WKT_OFF_CTRL) begin
			ctrl_r <= pwdata_i[`WKT_CTRL_W-1:0];
		end
	end

	// interrupt enable register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ien_r <= 1'b0;
		end else if (wr_fire && paddr_i == `WKT_OFF_IEN) begin
			ien_r <= pwdata_i[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// source selection and prescaler

	logic [2:0] osc_in;
	logic [2:0] osc_rise;
	logic src_tick;
	logic pre_tick;

	assign osc_in = {prec_osc_i, xtal_i, lp_osc_i};

	// oscillator edge detection keeps running with the core clock gated
	generate
		for (genvar g = 0; g < 3; g++) begin : g_osc
			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					osc_prev_r[g] <= 1'b0;
				end else begin
					osc_prev_r[g] <= osc_in[g];
				end
			end
			assign osc_rise[g] = osc_in[g] && !osc_prev_r[g];
		end
	endgenerate

	always_comb begin
		case (src)
			WKT_SRC_CORE: src_tick = core_clk_en_i;
			WKT_SRC_LPOSC: src_tick = osc_rise[0];
			WKT_SRC_XTAL: src_tick = osc_rise[1];
			WKT_SRC_PREC: src_tick = osc_rise[2];
			default: src_tick = 1'b0;
		endcase
	end

	assign pre_tick = count_en && src_tick && (pre_cnt_r >= mask);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pre_cnt_r <= 15'h0000;
		end else if (!count_en || pre_tick) begin
			pre_cnt_r <= 15'h0000;
		end else if (src_tick) begin
			pre_cnt_r <= pre_cnt_r + 15'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter

	logic hms;
	logic [31:0] top;
	logic at_end;
	logic timeout;

	assign hms = (fmt == WKT_FMT_HMS24) || (fmt == WKT_FMT_HMS255);
	always_comb begin
		case (fmt)
			WKT_FMT_HMS24:
				top = {`WKT_HR24_MAX, `WKT_SEC_MAX, `WKT_SEC_MAX, `WKT_HUN_MAX};
			WKT_FMT_HMS255:
				top = {`WKT_HR255_MAX, `WKT_SEC_MAX, `WKT_SEC_MAX, `WKT_HUN_MAX};
			default: top = 32'hffff_ffff;
		endcase
	end

	assign at_end = count_up ? (value_r == top) : (value_r == 32'h0000_0000);
	assign timeout = pre_tick && at_end;

	always_comb begin
		value_nxt = value_r;
		if (timeout) begin
			if (periodic) begin
				value_nxt = load_r;
			end else begin
				value_nxt = count_up ? 32'h0000_0000 : top;
			end
		end else if (pre_tick) begin
			if (hms) begin
				value_nxt = hms_step(value_r, count_up);
			end else if (count_up) begin
				value_nxt = value_r + 32'h0000_0001;
			end else begin
				value_nxt = value_r - 32'h0000_0001;
			end
		end
	end

	// writes to the value register are not decoded here
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			value_r <= `WKT_RST_VALUE;
		end else if (count_en) begin
			value_r <= value_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt

	logic clr_fire;

	assign clr_fire = wr_fire && paddr_i == `WKT_OFF_CLR;

	// a timeout in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stat_r <= 1'b0;
		end else if (timeout) begin
			stat_r <= 1'b1;
		end else if (clr_fire) begin
			stat_r <= 1'b0;
		end
	end

	assign irq_o = stat_r && ien_r;

endmodule : wkt_wakeup_timer

/* verif/wkt_wakeup_timer_asserts.sv */
// port checker of the wake-up timer
`timescale 1ns/1ns
`include "wkt_defs.svh"
module wkt_wakeup_timer_asserts (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb and interrupt
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic irq_o
);
	logic [31:0] load_r;
	logic [10:0] ctl_r;
	logic ien_r;
	logic ran_r;
	logic wr;
	logic rd;
	assign wr = psel_i && penable_i && pready_o && pwrite_i;
	assign rd = psel_i && penable_i && pready_o && !pwrite_i;
	// shadow of written registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			load_r <= '0;
			ctl_r <= '0;
			ien_r <= 1'b0;
			ran_r <= 1'b0;
		end else begin
			ran_r <= ran_r | ctl_r[7];
			if (wr && paddr_i == `WKT_OFF_LOAD) load_r <= pwdata_i;
			if (wr && paddr_i == `WKT_OFF_CTRL) ctl_r <= pwdata_i[10:0];
			if (wr && paddr_i == `WKT_OFF_IEN) ien_r <= pwdata_i[0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
	a_wait: assert property (p_wait) else $error("ready late");
	property p_one; pready_o |-> penable_i && $past(penable_i); endproperty
	a_one: assert property (p_one) else $error("ready early");
	property p_err; pready_o |-> pslverr_o == !(paddr_i inside {`WKT_OFF_LOAD,
		`WKT_OFF_VALUE, `WKT_OFF_CTRL, `WKT_OFF_CLR, `WKT_OFF_STAT,
		`WKT_OFF_IEN}); endproperty
	a_err: assert property (p_err) else $error("bad slave error");
	property p_zero; pready_o && (pwrite_i || pslverr_o
		|| paddr_i == `WKT_OFF_CLR) |-> prdata_o == '0; endproperty
	a_zero: assert property (p_zero) else $error("stray read data");
	property p_clr; wr && paddr_i == `WKT_OFF_CLR |=> !irq_o; endproperty
	a_clr: assert property (p_clr) else $error("irq not cleared");
	property p_load; rd && paddr_i == `WKT_OFF_LOAD |-> prdata_o == load_r;
	endproperty
	a_load: assert property (p_load) else $error("load readback");
	property p_ctl; rd && paddr_i == `WKT_OFF_CTRL |-> prdata_o == 32'(ctl_r);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control readback");
	property p_rst; rd && paddr_i == `WKT_OFF_VALUE && !ran_r
		|-> prdata_o == 32'hffff_ffff; endproperty
	a_rst: assert property (p_rst) else $error("value reset");
	property p_msk; irq_o |-> ien_r; endproperty
	a_msk: assert property (p_msk) else $error("irq unmasked");
	property p_rise; $rose(irq_o) && $past(ien_r) |-> $past(ctl_r[7]);
	endproperty
	a_rise: assert property (p_rise) else $error("halted timeout");
endmodule : wkt_wakeup_timer_asserts

bind wkt_wakeup_timer wkt_wakeup_timer_asserts u_wkt_wakeup_timer_asserts (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.irq_o(irq_o));

/* verif/wkt_wakeup_timer_tb.sv */
// self-checking bench of the wake-up timer
`timescale 1ns/1ns
`include "wkt_defs.svh"
module wkt_wakeup_timer_tb;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [31:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic irq_o;
	logic [3:0] src = '0;
	logic [31:0] q;
	logic [31:0] ev;
	logic err;
	int miscompares = 0;
	int tests_run = 0;
	int dv [3] = '{16, 256, 32768};
	int pc [3] = '{4, 8, 15};
	always #25 clk_i = ~clk_i;
	wkt_wakeup_timer u_wkt_wakeup_timer (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .core_clk_en_i(src[0]),
		.lp_osc_i(src[1]), .xtal_i(src[2]), .prec_osc_i(src[3]), .irq_o(irq_o));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] x, g);
		tests_run++;
		if (g !== x) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		chk("pready", 1, 32'(pready_o));
		q = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask : apb
	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rc(input logic [31:0] a, x);
		apb(1'b0, a, '0);
		chk($sformatf("reg %h", a), x, q);
	endtask : rc
	task automatic cv(input logic [31:0] x, input logic i);
		rc(`WKT_OFF_VALUE, x);
		chk("irq", 32'(i), 32'(irq_o));
	endtask : cv
	task automatic tk(input int s, input int n);
		repeat (n) begin
			src[s] <= 1'b1;
			@(posedge clk_i);
			src[s] <= 1'b0;
			@(posedge clk_i);
		end
		repeat (2) @(posedge clk_i);
	endtask : tk
	task automatic final_report;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge clk_i);
		miscompares++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rc(`WKT_OFF_LOAD, '0);
		rc(`WKT_OFF_CTRL, '0);
		wr(`WKT_OFF_VALUE, 32'h1234_5678);
		cv(32'hffff_ffff, 1'b0);
		rc(`WKT_OFF_CLR, '0);
		rc(32'hffff_0358, '0);
		chk("pslverr", 1, 32'(err));
		wr(`WKT_OFF_LOAD, 32'ha5a5_5a5a);
		rc(`WKT_OFF_LOAD, 32'ha5a5_5a5a);
		wr(`WKT_OFF_CTRL, 32'h0000_ffff);
		rc(`WKT_OFF_CTRL, 32'h0000_07ff);
		wr(`WKT_OFF_IEN, 32'h0000_0001);
		rc(`WKT_OFF_IEN, 32'h0000_0001);
		rc(`WKT_OFF_STAT, '0);
		$display("test registers done");
		wr(`WKT_OFF_CTRL, 32'h0000_0180);
		tk(0, 1);
		cv('0, 1'b1);
		tk(0, 2);
		cv(32'h0000_0002, 1'b1);
		wr(`WKT_OFF_CLR, 32'h0000_00ff);
		cv(32'h0000_0002, 1'b0);
		wr(`WKT_OFF_CTRL, 32'h0000_0100);
		tk(0, 3);
		cv(32'h0000_0002, 1'b0);
		$display("test free up done");
		wr(`WKT_OFF_LOAD, 32'h0001_0000);
		wr(`WKT_OFF_CTRL, 32'h0000_00c0);
		tk(0, 2);
		cv('0, 1'b0);
		wr(`WKT_OFF_IEN, '0);
		tk(0, 1);
		cv(32'h0001_0000, 1'b0);
		rc(`WKT_OFF_STAT, 32'h0000_0001);
		wr(`WKT_OFF_IEN, 32'h0000_0001);
		chk("irq", 1, 32'(irq_o));
		wr(`WKT_OFF_CLR, '0);
		rc(`WKT_OFF_STAT, '0);
		wr(`WKT_OFF_CTRL, 32'h0000_02e8);
		tk(1, 256);
		cv(32'h0000_3b63, 1'b0);
		wr(`WKT_OFF_CTRL, 32'h0000_03f8);
		tk(1, 256);
		cv(32'h0001_0000, 1'b0);
		$display("test periodic done");
		ev = 32'h0001_0000;
		for (int s = 1; s < 4; s++) begin
			wr(`WKT_OFF_CTRL, 32'(s << 9) | 32'h0000_0080);
			tk(0, 2);
			tk(s % 3 + 1, 1);
			tk(s, 1);
			ev--;
			cv(ev, 1'b0);
		end
		for (int i = 0; i < 3; i++) begin
			wr(`WKT_OFF_CTRL, '0);
			wr(`WKT_OFF_CTRL, 32'(pc[i]) | 32'h0000_0080);
			tk(0, dv[i] - 1);
			cv(ev, 1'b0);
			tk(0, 1);
			ev--;
			cv(ev, 1'b0);
		end
		$display("test sources done");
		wr(`WKT_OFF_CTRL, 32'h0000_0080);
		tk(0, 250);
		cv(32'h0000_ff00, 1'b0);
		wr(`WKT_OFF_CTRL, 32'h0000_0090);
		tk(0, 1);
		cv(32'h0000_feff, 1'b0);
		$display("test format done");
		final_report();
	end
endmodule : wkt_wakeup_timer_tb
